/* File: src/fsc_clk_div.sv */
`timescale 1ns/1ps
// flash_timing_clock generator: one tick every (div+1) bus clocks
module fsc_clk_div #(
  parameter int DIV_W = 7
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control
  input wire logic run_in,
  input wire logic [DIV_W-1:0] div_in,
  // tick out
  output logic tick_out
);
  import fsc_pkg::*;

  logic [DIV_W-1:0] cnt; // bus clocks into the current flash clock

  // counter restarts when idle so the first period is full length
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (ce_in) begin
      if (!run_in || cnt == div_in) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // tick marks the end of each flash timing clock cycle
  assign tick_out = run_in && ce_in && (cnt == div_in);
endmodule

/* File: src/fsc_pkg.sv */
package fsc_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_DIV = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_CMD = 4'h8;
  // flash_clock_divider fields: value in [6:0], loaded flag in bit 7
  localparam int DIV_VAL_W = 7;
  localparam int DIV_SET_BIT = 7;
  // flash_status_register field positions
  localparam int ST_CBEF = 7;
  localparam int ST_CCF = 6;
  localparam int ST_ACCERR = 5;
  localparam int ST_BLANK = 2;
  // reset values
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'hC0;
  localparam logic [7:0] CMD_RST = 8'h00;
  // flash_command_code values
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_SECTOR = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  localparam logic [7:0] CMD_ABORT = 8'h47;
  // operation lengths in flash_timing_clock cycles
  localparam logic [15:0] CYC_BYTE = 16'h0009;
  localparam logic [15:0] CYC_BURST = 16'h0004;
  localparam logic [15:0] CYC_ABORT = 16'h0004;
  localparam logic [15:0] CYC_SECTOR = 16'h0FA0;
  localparam logic [15:0] CYC_MASS = 16'h4E20;
  localparam logic [15:0] CYC_BLANK = 16'h0010;
  // sequencer states
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_LATCHED = 2'b01,
    SQ_CMDREADY = 2'b10,
    SQ_RUN = 2'b11
  } fsc_state_type;
  // operation shown to the arrays
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_BLANK = 3'b001,
    OP_BYTE = 3'b010,
    OP_BURST = 3'b011,
    OP_SECTOR = 3'b100,
    OP_MASS = 3'b101,
    OP_ABORT = 3'b110
  } fsc_op_type;
endpackage

/* File: src/fsc_sequencer.sv */
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
// flash and eeprom command sequencer with avalon register slave
module fsc_sequencer #(
  parameter int ADDR_W = 17,
  parameter int SECTOR_W = 9,
  parameter logic [15:0] MASS_CYCLES = fsc_pkg::CYC_MASS
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // avalon-mm register slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // cpu writes into the memory arrays
  input wire logic mem_wr_in,
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire logic [7:0] mem_data_in,
  input wire logic mem_eeprom_in,
  // array control
  output fsc_pkg::fsc_op_type arr_op_out,
  output logic arr_hv_out,
  output logic arr_step_out,
  output logic [ADDR_W-1:0] arr_addr_out,
  output logic [7:0] arr_data_out,
  output logic arr_eeprom_out,
  input wire logic arr_blank_in
);
  import fsc_pkg::*;

  // bus handshake
  logic acc; // second cycle of an access, waitrequest released
  logic fire; // access completes at this edge
  logic wr_div, wr_stat, wr_cmd;
  logic [7:0] wbyte;
  // registers
  logic [DIV_VAL_W-1:0] div_val; // flash_clock_divider value
  logic div_set; // divider loaded since reset
  logic [7:0] cmd_q; // command buffer
  logic cbef, ccf, accerr, blank; // status flags
  // interface latches
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q;
  logic tgt_q; // 1 targets the eeprom
  // sequencer
  fsc_state_type state;
  fsc_op_type op_q;
  logic [15:0] cnt; // flash timing cycles left
  logic tick;
  // events
  logic ev_latch, ev_cmd, ev_launch, ev_launch_ok, ev_abort, ev_seq_err;
  logic ev_err, ev_done;
  fsc_op_type next_op;

  // map a command code to an operation, illegal codes give none
  function automatic fsc_op_type decode(input logic [7:0] c);
    case (c)
      CMD_BLANK: decode = OP_BLANK;
      CMD_BYTE: decode = OP_BYTE;
      CMD_BURST: decode = OP_BURST;
      CMD_SECTOR: decode = OP_SECTOR;
      CMD_MASS: decode = OP_MASS;
      CMD_ABORT: decode = OP_ABORT;
      default: decode = OP_NONE;
    endcase
  endfunction

  // cycle count of each operation
  function automatic logic [15:0] length(input fsc_op_type o);
    case (o)
      OP_BYTE: length = CYC_BYTE;
      OP_BURST: length = CYC_BURST;
      OP_ABORT: length = CYC_ABORT;
      OP_SECTOR: length = CYC_SECTOR;
      OP_MASS: length = MASS_CYCLES;
      default: length = CYC_BLANK;
    endcase
  endfunction

  // one wait state on every access keeps read data registered;
  // a low clock enable keeps waitrequest up so no access is lost
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !(acc && ce_in);
  assign fire = ce_in && acc && (avs_read_in || avs_write_in);
  assign wbyte = avs_writedata_in[7:0];
  // writes only count when the low byte lane is enabled
  assign wr_div = fire && avs_write_in && avs_byteenable_in[0] && avs_address_in == OFS_DIV;
  assign wr_stat = fire && avs_write_in && avs_byteenable_in[0] && avs_address_in == OFS_STAT;
  assign wr_cmd = fire && avs_write_in && avs_byteenable_in[0] && avs_address_in == OFS_CMD;

  // access phase tracking
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc <= 1'b0;
    end else if (ce_in) begin
      acc <= (avs_read_in || avs_write_in) && !acc;
    end
  end

  // read data captured in the wait cycle, unmapped offsets read zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (ce_in && avs_read_in && !acc) begin
      case (avs_address_in)
        OFS_DIV: avs_readdata_out <= {24'h00_0000, div_set, div_val};
        OFS_STAT: avs_readdata_out <= {24'h00_0000, cbef, ccf, accerr, 2'b00, blank, 2'b00};
        OFS_CMD: avs_readdata_out <= {24'h00_0000, cmd_q};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // sequence events
  assign ev_latch = mem_wr_in && ce_in && state == SQ_IDLE && !accerr;
  assign ev_cmd = wr_cmd && state == SQ_LATCHED;
  assign ev_launch = wr_stat && wbyte[ST_CBEF] && state == SQ_CMDREADY;
  assign next_op = decode(cmd_q);
  // launch needs a clean flag, a loaded divider and a legal code
  assign ev_launch_ok = ev_launch && !accerr && div_set && next_op != OP_NONE;
  // zero into the empty flag between array write and launch
  assign ev_abort = wr_stat && !wbyte[ST_CBEF]
                    && (state == SQ_LATCHED || state == SQ_CMDREADY);
  // out-of-order steps: a second array write, a second command, a command with no array
  // write, or a launch with nothing buffered
  assign ev_seq_err = (mem_wr_in && ce_in && (state == SQ_LATCHED || state == SQ_CMDREADY))
                      || (wr_cmd && (state == SQ_IDLE || state == SQ_CMDREADY))
                      || (wr_stat && wbyte[ST_CBEF] && state == SQ_LATCHED);
  assign ev_err = (ev_launch && !ev_launch_ok) || ev_abort || ev_seq_err;
  assign ev_done = state == SQ_RUN && tick && cnt == 16'h0001;

  // flash_clock_divider, held steady while a command runs
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      div_val <= DIV_RST[DIV_VAL_W-1:0];
      div_set <= DIV_RST[DIV_SET_BIT];
    end else if (wr_div && state != SQ_RUN) begin
      div_val <= wbyte[DIV_VAL_W-1:0];
      div_set <= 1'b1;
    end
  end

  // command buffer holds the code until launch
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cmd_q <= CMD_RST;
    end else if (ev_cmd) begin
      cmd_q <= wbyte;
    end
  end

  // address and data latches from the first array write
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      addr_q <= '0;
      data_q <= 8'h00;
      tgt_q <= 1'b0;
    end else if (ev_latch) begin
      addr_q <= mem_addr_in;
      data_q <= mem_data_in;
      tgt_q <= mem_eeprom_in;
    end
  end

  // flash timing clock, running only during a command
  fsc_clk_div #(
    .DIV_W(DIV_VAL_W)
  ) u_div (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .run_in(state == SQ_RUN),
    .div_in(div_val),
    .tick_out(tick)
  );
  assign arr_step_out = tick;

  // sequence state machine
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= SQ_IDLE;
    end else if (ce_in) begin
      unique case (state)
        SQ_IDLE: begin
          if (ev_latch) begin
            state <= SQ_LATCHED;
          end
        end
        SQ_LATCHED: begin
          if (ev_err) begin
            state <= SQ_IDLE;
          end else if (ev_cmd) begin
            state <= SQ_CMDREADY;
          end
        end
        SQ_CMDREADY: begin
          if (ev_launch_ok) begin
            state <= SQ_RUN;
          end else if (ev_err) begin
            state <= SQ_IDLE;
          end
        end
        SQ_RUN: begin
          // nothing from the bus can cut a running operation short
          if (ev_done) begin
            state <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  // operation counter, decremented once per flash timing cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= 16'h0000;
    end else if (ev_launch_ok) begin
      cnt <= length(next_op);
    end else if (state == SQ_RUN && tick) begin
      cnt <= cnt - 16'h0001;
    end
  end

  // array drive registers, set at launch; operation and high voltage dropped at completion, address, data and target held
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      op_q <= OP_NONE;
      arr_hv_out <= 1'b0;
      arr_addr_out <= '0;
      arr_data_out <= 8'h00;
      arr_eeprom_out <= 1'b0;
    end else if (ev_launch_ok) begin
      op_q <= next_op;
      // blank check and abort only sense, no high voltage needed
      arr_hv_out <= next_op inside {OP_BYTE, OP_BURST, OP_SECTOR, OP_MASS};
      // sector erase points at the sector base whatever was written
      if (next_op == OP_SECTOR) begin
        arr_addr_out <= {addr_q[ADDR_W-1:SECTOR_W], {SECTOR_W{1'b0}}};
      end else begin
        arr_addr_out <= addr_q;
      end
      // data only matters when programming
      if (next_op == OP_BYTE || next_op == OP_BURST) begin
        arr_data_out <= data_q;
      end else begin
        arr_data_out <= 8'h00;
      end
      arr_eeprom_out <= tgt_q;
    end else if (ev_done) begin
      op_q <= OP_NONE;
      arr_hv_out <= 1'b0;
    end
  end
  assign arr_op_out = op_q;

  // status flags; hardware set wins over a software clear
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cbef <= STAT_RST[ST_CBEF];
      ccf <= STAT_RST[ST_CCF];
      accerr <= STAT_RST[ST_ACCERR];
      blank <= STAT_RST[ST_BLANK];
    end else begin
      if (ev_err) begin
        accerr <= 1'b1;
      end else if (wr_stat && wbyte[ST_ACCERR]) begin
        accerr <= 1'b0;
      end
      if (ev_launch_ok) begin
        cbef <= 1'b0;
        ccf <= 1'b0;
        blank <= 1'b0;
      end else if (ev_done) begin
        cbef <= 1'b1;
        ccf <= 1'b1;
        if (op_q == OP_BLANK) begin
          blank <= arr_blank_in;
        end
      end
    end
  end

  // ticks seen in the current operation, read only by checks below
  logic [15:0] tk_seen;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || state != SQ_RUN) begin
      tk_seen <= 16'h0000;
    end else if (tick) begin
      tk_seen <= tk_seen + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  property p_latch;
    ev_latch |=> state == SQ_LATCHED && addr_q == $past(mem_addr_in)
                 && data_q == $past(mem_data_in);
  endproperty
  a_latch: assert property (p_latch) else $error("array write not latched");

  property p_cmd_store;
    ev_cmd |=> cmd_q == $past(wbyte) && state == SQ_CMDREADY;
  endproperty
  a_cmd_store: assert property (p_cmd_store) else $error("command not buffered");

  property p_launch;
    ev_launch && !accerr && div_set && decode(cmd_q) != OP_NONE
      |=> !cbef && state == SQ_RUN && arr_op_out == decode($past(cmd_q));
  endproperty
  a_launch: assert property (p_launch) else $error("launch failed");

  property p_abort;
    ev_abort |=> accerr && state == SQ_IDLE && cbef;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not flag");

  property p_bad_code;
    ev_launch && decode(cmd_q) == OP_NONE |=> accerr && state == SQ_IDLE;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code ran");

  property p_done;
    ev_done |=> cbef && ccf && arr_op_out == OP_NONE && !arr_hv_out;
  endproperty
  a_done: assert property (p_done) else $error("completion not reported");

  property p_byte_len;
    ev_done && op_q == OP_BYTE |-> tk_seen == 16'h0008;
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("byte program length");

  property p_burst_len;
    ev_done && op_q inside {OP_BURST, OP_ABORT} |-> tk_seen == 16'h0003;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("short op length");

  property p_sector_len;
    ev_done && op_q == OP_SECTOR |-> tk_seen == 16'h0F9F;
  endproperty
  a_sector_len: assert property (p_sector_len) else $error("sector erase length");

  property p_sector_addr;
    op_q == OP_SECTOR |-> arr_addr_out[SECTOR_W-1:0] == '0;
  endproperty
  a_sector_addr: assert property (p_sector_addr) else $error("sector not aligned");

  property p_erase_data;
    op_q inside {OP_SECTOR, OP_MASS, OP_BLANK} |-> arr_data_out == 8'h00;
  endproperty
  a_erase_data: assert property (p_erase_data) else $error("erase data not ignored");

  property p_step;
    arr_step_out |-> state == SQ_RUN && (div_val == '0 || !$past(arr_step_out));
  endproperty
  a_step: assert property (p_step) else $error("flash tick misplaced");

  property p_target;
    ev_launch_ok |=> arr_eeprom_out == tgt_q;
  endproperty
  a_target: assert property (p_target) else $error("wrong array target");
endmodule

/* File: testbench/fsc_array_model.sv */
`timescale 1ns/1ps
// behavioural flash and eeprom arrays; only the blank state is modelled
module fsc_array_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // array control from the sequencer
  input wire fsc_pkg::fsc_op_type op_in,
  input wire logic eeprom_in,
  // blank result back
  output logic blank_out
);
  import fsc_pkg::*;
  logic [1:0] blank; // bit 1 eeprom, bit 0 flash; both start programmed
  // each memory keeps its own state, so an erase of one never blanks the other
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      blank <= 2'b00;
    end else if (op_in == OP_MASS || op_in == OP_SECTOR) begin
      blank[eeprom_in] <= 1'b1;
    end else if (op_in == OP_BYTE || op_in == OP_BURST) begin
      blank[eeprom_in] <= 1'b0;
    end
  end
  // result follows the selected memory only
  assign blank_out = blank[eeprom_in];
endmodule

/* File: testbench/fsc_sequencer_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the command sequencer
module fsc_sequencer_tb;
  import fsc_pkg::*;
  localparam logic [15:0] MASS_SIM = 16'h0020; // short mass erase keeps the run brief
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1; // held for two edges
  logic ce = 1'b1; // clock enable, dropped once to check the freeze
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mem_wr = 1'b0;
  logic [16:0] mem_addr = 17'h0_0000;
  logic [7:0] mem_data = 8'h00;
  logic mem_eeprom = 1'b0;
  fsc_op_type arr_op;
  logic arr_hv;
  logic arr_step;
  logic [16:0] arr_addr;
  logic [7:0] arr_data;
  logic arr_eeprom;
  logic arr_blank;
  int errors = 0;
  int comparisons = 0;
  logic [7:0] q;

  // 20 mhz bus clock
  always #25 clk_sys_in = ~clk_sys_in;

  fsc_sequencer #(.MASS_CYCLES(MASS_SIM)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_byteenable_in(avs_byteenable), .avs_writedata_in(avs_writedata),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
    .mem_wr_in(mem_wr), .mem_addr_in(mem_addr), .mem_data_in(mem_data),
    .mem_eeprom_in(mem_eeprom), .arr_op_out(arr_op), .arr_hv_out(arr_hv),
    .arr_step_out(arr_step), .arr_addr_out(arr_addr), .arr_data_out(arr_data),
    .arr_eeprom_out(arr_eeprom), .arr_blank_in(arr_blank)
  );

  // far side: the memory arrays
  fsc_array_model arrays (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .op_in(arr_op),
    .eeprom_in(arr_eeprom), .blank_out(arr_blank)
  );

  // one comparison, counted; case inequality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // avalon transfer; request held until waitrequest is sampled low at a rising
  // edge, data taken at that edge; only the watchdog ends a stuck wait
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] dat,
                     input logic [3:0] be, output logic [7:0] rdat);
    @(posedge clk_sys_in);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= {24'h00_0000, dat};
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys_in);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // full-byte register write
  task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
    logic [7:0] r;
    bus(1'b1, adr, dat, 4'hF, r);
  endtask

  // register read compared with an expected byte
  task automatic rd(input logic [3:0] adr, input logic [7:0] exp, input string what);
    logic [7:0] r;
    bus(1'b0, adr, 8'h00, 4'hF, r);
    chk({24'h00_0000, r}, {24'h00_0000, exp}, what);
  endtask

  // one cpu write into an array, the first step of every sequence
  task automatic memw(input logic [16:0] a, input logic [7:0] d, input logic e);
    @(posedge clk_sys_in);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_data <= d;
    mem_eeprom <= e;
    @(posedge clk_sys_in);
    mem_wr <= 1'b0;
  endtask

  // complete sequence, then watch the array side until the run ends
  task automatic run(input logic [7:0] code, input logic [16:0] a, input logic [7:0] d,
                     input logic e, input fsc_op_type op, input int steps, input int div,
                     input logic [16:0] ea, input logic [7:0] ed, input logic hv,
                     input logic [7:0] st);
    int s;
    int c;
    s = 0;
    c = 0;
    memw(a, d, e);
    wr(OFS_CMD, code);
    wr(OFS_STAT, 8'h80);
    @(negedge clk_sys_in);
    chk(arr_op, op, "operation");
    chk(arr_addr, ea, "address");
    chk(arr_data, ed, "data");
    chk(arr_hv, hv, "high voltage");
    chk(arr_eeprom, e, "target");
    // bounded wait for the run to finish
    while (arr_op !== OP_NONE && c < 30000) begin
      c++;
      if (arr_step === 1'b1) begin
        s++;
      end
      @(negedge clk_sys_in);
    end
    chk(s, steps, "step count");
    chk(c, steps * (div + 1), "run length");
    rd(OFS_STAT, st, "status after run");
    $display("test command %h done", code);
  endtask

  // sequence that must end in the access error flag and no run
  task automatic bad(input logic cmd, input logic [7:0] code, input logic [7:0] st);
    memw(17'h0_0020, 8'h11, 1'b0);
    if (cmd) begin
      wr(OFS_CMD, code);
    end
    wr(OFS_STAT, st);
    @(negedge clk_sys_in);
    chk(arr_op, OP_NONE, "refused launch");
    rd(OFS_STAT, 8'hE0, "error flag set");
    wr(OFS_STAT, 8'h20);
    rd(OFS_STAT, 8'hC0, "error flag cleared");
    $display("test error path done");
  endtask

  // single closing point for the run
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(OFS_STAT, STAT_RST, "status reset");
    rd(OFS_DIV, DIV_RST, "divider reset");
    rd(OFS_CMD, CMD_RST, "command reset");
    rd(4'hC, 8'h00, "unmapped read");
    $display("test reset values done");
    bad(1'b1, CMD_BYTE, 8'h80);
    // write without the low byte lane is dropped
    bus(1'b1, OFS_DIV, 8'h05, 4'hE, q);
    rd(OFS_DIV, 8'h00, "masked write");
    // array write with the clock enable low is lost, so the command is out of order
    @(posedge clk_sys_in);
    ce <= 1'b0;
    memw(17'h0_0020, 8'h11, 1'b0);
    ce <= 1'b1;
    wr(OFS_CMD, CMD_BYTE);
    rd(OFS_STAT, 8'hE0, "frozen array write");
    wr(OFS_STAT, 8'h20);
    rd(OFS_STAT, 8'hC0, "error flag cleared");
    $display("test clock enable done");
    wr(OFS_DIV, 8'h00);
    rd(OFS_DIV, 8'h80, "divider loaded");
    run(CMD_MASS, 17'h0_0123, 8'h5A, 1'b1, OP_MASS, 32, 0, 17'h0_0123, 8'h00, 1'b1,
        8'hC0);
    run(CMD_BLANK, 17'h0_0456, 8'h99, 1'b1, OP_BLANK, 16, 0, 17'h0_0456, 8'h00, 1'b0,
        8'hC4);
    run(CMD_BLANK, 17'h0_0456, 8'h99, 1'b0, OP_BLANK, 16, 0, 17'h0_0456, 8'h00, 1'b0,
        8'hC0);
    // byte program goes to the eeprom just mass erased
    wr(OFS_DIV, 8'h01);
    rd(OFS_DIV, 8'h81, "divider reloaded");
    run(CMD_BYTE, 17'h0_0345, 8'hA5, 1'b1, OP_BYTE, 9, 1, 17'h0_0345, 8'hA5, 1'b1,
        8'hC0);
    wr(OFS_DIV, 8'h00);
    run(CMD_BURST, 17'h0_0011, 8'h3C, 1'b1, OP_BURST, 4, 0, 17'h0_0011, 8'h3C, 1'b1,
        8'hC0);
    run(CMD_SECTOR, 17'h1_23FF, 8'h77, 1'b0, OP_SECTOR, 4000, 0, 17'h1_2200, 8'h00, 1'b1,
        8'hC0);
    run(CMD_ABORT, 17'h1_2200, 8'h00, 1'b0, OP_ABORT, 4, 0, 17'h1_2200, 8'h00, 1'b0,
        8'hC0);
    bad(1'b0, 8'h00, 8'h00);
    bad(1'b1, CMD_BYTE, 8'h00);
    bad(1'b1, 8'h33, 8'h80);
    rd(OFS_CMD, 8'h33, "command buffer");
    summarize();
  end

  // watchdog sized well above the expected length of the sequence
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
